// >>> design/dpc_pkg.sv
/*
 Package for the dual-port memory host controller: pin timing, widths, commands.
 Assumes a 250 MHz system clock; all pin timing is counted in its cycles.
*/
package dpc_pkg;
	localparam int unsigned CLK_PERIOD_PS = 4000;
	localparam int unsigned ADDR_W        = 14;
	localparam int unsigned DATA_W        = 16;
	// Pin timing in ns
	localparam int unsigned T_RC_NS   = 55;   // Read cycle
	localparam int unsigned T_PWE_NS  = 40;   // Write pulse width
	localparam int unsigned T_SA_NS   = 0;    // Address setup to write start
	localparam int unsigned T_HZ_NS   = 25;   // Output turn-off after strobe
	localparam int unsigned T_SOP_NS  = 15;   // Flag update pulse
	localparam int unsigned T_SWRD_NS = 10;   // Flag write to read
	localparam int unsigned T_WH_NS   = 35;   // Strobe hold after indicator high
	localparam int unsigned T_BDD_NS  = 40;   // Indicator high to data valid
	localparam int unsigned T_SAA_NS  = 55;   // Flag access time
	// Least times round up to whole cycles, never under one
	function automatic int unsigned dpc_min_cyc(input int unsigned ns);
		int unsigned c;
		c = (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
		return (c < 1) ? 1 : c;
	endfunction : dpc_min_cyc
	localparam int unsigned RD_CYC   = dpc_min_cyc(T_RC_NS);
	localparam int unsigned WR_CYC   = dpc_min_cyc(T_PWE_NS + T_HZ_NS);
	localparam int unsigned SA_CYC   = dpc_min_cyc(T_SA_NS);
	localparam int unsigned SOP_CYC  = dpc_min_cyc(T_SOP_NS);
	localparam int unsigned SWRD_CYC = dpc_min_cyc(T_SWRD_NS);
	localparam int unsigned WH_CYC   = dpc_min_cyc(T_WH_NS);
	localparam int unsigned BDD_CYC  = dpc_min_cyc(T_BDD_NS);
	localparam int unsigned SAA_CYC  = dpc_min_cyc(T_SAA_NS);
	localparam int unsigned CNT_W    = 6;
	// Host commands
	typedef enum logic [1:0] {
		DPC_CMD_READ  = 2'h0,
		DPC_CMD_WRITE = 2'h1,
		DPC_CMD_CLAIM = 2'h2,
		DPC_CMD_FREE  = 2'h3
	} dpc_cmd_t;
	localparam logic [DATA_W-1:0] RST_DATA = 16'h0000;
	localparam logic [ADDR_W-1:0] RST_ADDR = 14'h0000;
	localparam logic [2:0]        FLAG_RST = 3'h0;
endpackage : dpc_pkg

// >>> design/dpc_sync.sv
/*
 Three-stage input synchroniser; a change is accepted once stages two and three agree.
 Assumes the input is asynchronous to sys_clk_i.
*/
`timescale 1ns/1ps
module dpc_sync
	import dpc_pkg::*;
#(
	parameter logic RST_VAL = 1'b1
) (
	input  wire logic sys_clk_i,
	input  wire logic rst_i,
	input  wire logic async_i,
	output logic      sync_o
);
	logic s1_ff, s2_ff, s3_ff, out_ff;
	logic nxt_out;
	// Accept only when the last two stages agree
	always_comb begin
		nxt_out = (s2_ff == s3_ff) ? s3_ff : out_ff;
	end
	// Stage registers
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			s1_ff  <= RST_VAL;
			s2_ff  <= RST_VAL;
			s3_ff  <= RST_VAL;
			out_ff <= RST_VAL;
		end else begin
			s1_ff  <= async_i;
			s2_ff  <= s1_ff;
			s3_ff  <= s2_ff;
			out_ff <= nxt_out;
		end
	end
	assign sync_o = out_ff;
endmodule : dpc_sync

// >>> design/dpc_host.sv
/*
 Host-side controller for one port of an asynchronous dual-port memory.
 Drives select, strobes, byte lanes and address; claims and frees flags; waits on
 the collision indicator. Assumes the memory pins are wired straight to this
 module and the data bus is resolved from data_oe_o outside.
*/
// Contract
// - Write strobe stays high through every read cycle.
// - Flag reads never use address-only reads; select toggles each access.
// - Upper and lower lane enables select bytes; flag select high for memory.
// - Write strobe is high whenever the address changes.
// - Port select stays high across flag write and read-back.
// - Flag read-back waits the flag write-to-read interval.
// - In slave mode strobe stays low a minimum time after indicator rises.
`timescale 1ns/1ps
module dpc_host
	import dpc_pkg::*;
(
	input  wire logic              sys_clk_i,
	input  wire logic              rst_i,
	input  wire logic              req_valid_i,
	output logic                   req_ready_o,
	input  wire dpc_cmd_t          req_cmd_i,
	input  wire logic [ADDR_W-1:0] req_addr_i,
	input  wire logic [DATA_W-1:0] req_wdata_i,
	input  wire logic [1:0]        req_lanes_i,
	input  wire logic              slave_mode_i,
	output logic                   rsp_valid_o,
	output logic [DATA_W-1:0]      rsp_rdata_o,
	output logic                   rsp_granted_o,
	output logic                   alert_o,
	output logic                   port_sel_n_o,
	output logic                   flag_select_n_o,
	output logic                   wr_n_o,
	output logic                   rd_oe_n_o,
	output logic                   upper_lane_n_o,
	output logic                   lower_lane_n_o,
	output logic [ADDR_W-1:0]      addr_o,
	input  wire logic [DATA_W-1:0] data_i,
	output logic [DATA_W-1:0]      data_o,
	output logic                   data_oe_o,
	input  wire logic              busy_n_i,
	input  wire logic              alert_n_i
);
	typedef enum logic [6:0] {
		ST_IDLE  = 7'b0000001,
		ST_SETUP = 7'b0000010,
		ST_READ  = 7'b0000100,
		ST_WRITE = 7'b0001000,
		ST_HOLD  = 7'b0010000,
		ST_GAP   = 7'b0100000,
		ST_FRD   = 7'b1000000
	} dpc_state_t;

	dpc_state_t        state_ff, nxt_state;
	dpc_cmd_t          cmd_ff, nxt_cmd;
	logic [CNT_W-1:0]  cnt_ff, nxt_cnt;
	logic [ADDR_W-1:0] addr_ff, nxt_addr;
	logic [DATA_W-1:0] wdata_ff, nxt_wdata, rdata_ff, nxt_rdata;
	logic [1:0]        lanes_ff, nxt_lanes;
	logic              rsp_ff, nxt_rsp, grant_ff, nxt_grant;
	logic              busy_n_s, alert_n_s;
	logic              is_flag;

	// Collision indicator and mailbox alert come from the far device
	dpc_sync #(.RST_VAL(1'b1)) u_sync_busy (
		.sys_clk_i (sys_clk_i),
		.rst_i     (rst_i),
		.async_i   (busy_n_i),
		.sync_o    (busy_n_s)
	);
	dpc_sync #(.RST_VAL(1'b1)) u_sync_alert (
		.sys_clk_i (sys_clk_i),
		.rst_i     (rst_i),
		.async_i   (alert_n_i),
		.sync_o    (alert_n_s)
	);

	assign is_flag = (cmd_ff == DPC_CMD_CLAIM) || (cmd_ff == DPC_CMD_FREE);

	// Sequencer: one access per request (a claim adds a flag read-back), every access bracketed by idle strobes
	always_comb begin
		nxt_state     = state_ff;
		nxt_cmd       = cmd_ff;
		nxt_cnt       = cnt_ff;
		nxt_addr      = addr_ff;
		nxt_wdata     = wdata_ff;
		nxt_rdata     = rdata_ff;
		nxt_lanes     = lanes_ff;
		nxt_rsp       = 1'b0;
		nxt_grant     = grant_ff;
		unique case (state_ff)
			ST_IDLE: begin
				if (req_valid_i) begin
					// Address loads only while all strobes are idle
					nxt_cmd       = req_cmd_i;
					nxt_addr      = req_addr_i;
					nxt_wdata     = req_wdata_i;
					nxt_lanes     = req_lanes_i;
					nxt_cnt       = CNT_W'(SA_CYC);
					nxt_state     = ST_SETUP;
				end
			end
			ST_SETUP: begin
				// Address settles before any select falls
				if (cnt_ff <= CNT_W'(1)) begin
					if (cmd_ff == DPC_CMD_READ) begin
						// Pins lag state by a cycle, so count one more to sample while selected
						nxt_cnt   = CNT_W'(RD_CYC + 1);
						nxt_state = ST_READ;
					end else begin
						nxt_cnt   = CNT_W'((cmd_ff == DPC_CMD_WRITE) ? WR_CYC : SOP_CYC);
						nxt_state = ST_WRITE;
					end
				end else begin
					nxt_cnt = cnt_ff - CNT_W'(1);
				end
			end
			ST_READ: begin
				// Held off by the indicator: wait for release plus data delay
				if (!busy_n_s) begin
					nxt_cnt = CNT_W'(BDD_CYC);
				end else if (cnt_ff <= CNT_W'(1)) begin
					nxt_rdata = data_i;
					nxt_rsp   = 1'b1;
					nxt_cnt   = CNT_W'(1);
					nxt_state = ST_GAP;
				end else begin
					nxt_cnt = cnt_ff - CNT_W'(1);
				end
			end
			ST_WRITE: begin
				// Slave mode: a low indicator suppresses the write, so hold on
				if (slave_mode_i && !busy_n_s) begin
					nxt_cnt = CNT_W'(WH_CYC);
				end else if (cnt_ff <= CNT_W'(1)) begin
					if (is_flag) begin
						nxt_cnt   = CNT_W'(SWRD_CYC);
						nxt_state = ST_HOLD;
					end else begin
						nxt_rsp   = 1'b1;
						nxt_cnt   = CNT_W'(1);
						nxt_state = ST_GAP;
					end
				end else begin
					nxt_cnt = cnt_ff - CNT_W'(1);
				end
			end
			ST_HOLD: begin
				// Flag write-to-read gap before the read-back
				if (cnt_ff <= CNT_W'(1)) begin
					if (cmd_ff == DPC_CMD_CLAIM) begin
						nxt_cnt   = CNT_W'(SAA_CYC + 1); // Pins lag state by a cycle
						nxt_state = ST_FRD;
					end else begin
						nxt_rsp   = 1'b1;
						nxt_cnt   = CNT_W'(1);
						nxt_state = ST_GAP;
					end
				end else begin
					nxt_cnt = cnt_ff - CNT_W'(1);
				end
			end
			ST_FRD: begin
				// Read-back low means this port owns the flag
				if (cnt_ff <= CNT_W'(1)) begin
					nxt_rdata = data_i;
					nxt_grant = ~data_i[0];
					nxt_rsp   = 1'b1;
					nxt_cnt   = CNT_W'(1);
					nxt_state = ST_GAP;
				end else begin
					nxt_cnt = cnt_ff - CNT_W'(1);
				end
			end
			ST_GAP: begin
				// One idle cycle so flag select rises between accesses
				nxt_state = ST_IDLE;
			end
		endcase
	end

	// Sequencer registers
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			state_ff     <= ST_IDLE;
			cmd_ff       <= DPC_CMD_READ;
			cnt_ff       <= '0;
			addr_ff      <= RST_ADDR;
			wdata_ff     <= RST_DATA;
			rdata_ff     <= RST_DATA;
			lanes_ff     <= 2'h0;
			rsp_ff       <= 1'b0;
			grant_ff     <= 1'b0;
		end else begin
			state_ff     <= nxt_state;
			cmd_ff       <= nxt_cmd;
			cnt_ff       <= nxt_cnt;
			addr_ff      <= nxt_addr;
			wdata_ff     <= nxt_wdata;
			rdata_ff     <= nxt_rdata;
			lanes_ff     <= nxt_lanes;
			rsp_ff       <= nxt_rsp;
			grant_ff     <= nxt_grant;
		end
	end

	// Pin drive, registered; all strobes are high outside an access
	logic [6:0] pins_ff, nxt_pins;
	logic       acc, wr_act, rd_act;
	always_comb begin
		acc    = (state_ff == ST_READ) || (state_ff == ST_WRITE) || (state_ff == ST_FRD);
		wr_act = (state_ff == ST_WRITE);
		rd_act = (state_ff == ST_READ) || (state_ff == ST_FRD);
		// Bits: port_sel, flag_sel, wr, oe, upper, lower, data_oe
		nxt_pins[6] = !(acc && !is_flag);                 // Port select high for flags
		nxt_pins[5] = !(acc && is_flag);                  // Flag select high for memory
		nxt_pins[4] = !wr_act;                            // Strobe high on reads
		nxt_pins[3] = !rd_act;
		nxt_pins[2] = !(acc && (is_flag || lanes_ff[1])); // Lane overlap bounds write
		nxt_pins[1] = !(acc && (is_flag || lanes_ff[0]));
		nxt_pins[0] = wr_act || !pins_ff[4];              // Data held a cycle past strobe
	end
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			pins_ff <= 7'h7e;
		end else begin
			pins_ff <= nxt_pins;
		end
	end

	assign port_sel_n_o    = pins_ff[6];
	assign flag_select_n_o = pins_ff[5];
	assign wr_n_o          = pins_ff[4];
	assign rd_oe_n_o       = pins_ff[3];
	assign upper_lane_n_o  = pins_ff[2];
	assign lower_lane_n_o  = pins_ff[1];
	assign data_oe_o       = pins_ff[0];
	assign addr_o          = addr_ff;
	// Claim drives data bit low, free drives it high
	assign data_o          = (cmd_ff == DPC_CMD_CLAIM) ? 16'hfffe :
	                         (cmd_ff == DPC_CMD_FREE) ? 16'hffff : wdata_ff;
	assign req_ready_o     = (state_ff == ST_IDLE);
	assign rsp_valid_o     = rsp_ff;
	assign rsp_rdata_o     = rdata_ff;
	assign rsp_granted_o   = grant_ff;
	// Mailbox alert from the partner, active high here
	assign alert_o         = ~alert_n_s;
endmodule : dpc_host

// >>> tb/dpc_dev_model.sv
/*
 Behavioural model of one port of the dual-port memory, with a stand-in far port.
 Assumes the bench resolves the data bus and drives the far-port controls.
*/
`timescale 1ns/1ps
module dpc_dev_model #(
	parameter logic [13:0] MBOX_ADDR = 14'h3fff
) (
	input  wire logic        port_sel_n_i,
	input  wire logic        flag_select_n_i,
	input  wire logic        wr_n_i,
	input  wire logic        rd_oe_n_i,
	input  wire logic        upper_lane_n_i,
	input  wire logic        lower_lane_n_i,
	input  wire logic [13:0] addr_i,
	input  wire logic [15:0] wdata_i,
	input  wire logic        slave_mode_i,
	input  wire logic        hold_busy_i,
	input  wire logic [7:0]  peer_own_i,
	input  wire logic        peer_mail_i,
	output logic [15:0]      rdata_o,
	output logic             drive_o,
	output logic             busy_n_o,
	output logic             alert_n_o
);
	logic [15:0] mem [0:16383];
	logic [7:0]  own;
	logic        mbox;
	initial begin
		foreach (mem[i]) mem[i] = 16'h0000;
		own = 8'h00;
		mbox = 1'b0;
	end
	// Far port sits on the same place while selected
	assign busy_n_o = !(hold_busy_i && !port_sel_n_i);
	assign alert_n_o = !mbox;
	// Outputs stay off unless reading with strobe high
	assign drive_o = !rd_oe_n_i && wr_n_i && (!port_sel_n_i || !flag_select_n_i);
	// Writes land while select overlaps a lane; slave writes gated by busy
	always @* begin
		if (!port_sel_n_i && !wr_n_i && !(slave_mode_i && !busy_n_o)) begin
			if (!upper_lane_n_i) mem[addr_i][15:8] = wdata_i[15:8];
			if (!lower_lane_n_i) mem[addr_i][7:0] = wdata_i[7:0];
		end
		if (!flag_select_n_i && !wr_n_i)
			own[addr_i[2:0]] = !wdata_i[0] && !peer_own_i[addr_i[2:0]];
		if (!port_sel_n_i && drive_o && addr_i == MBOX_ADDR)
			mbox = 1'b0;
	end
	always @(posedge peer_mail_i) mbox = 1'b1;
	// Read data; disabled lanes and held-off reads show junk
	always @* begin
		rdata_o = mem[addr_i];
		if (!flag_select_n_i) rdata_o = {15'h7fff, !own[addr_i[2:0]]};
		if (upper_lane_n_i && flag_select_n_i) rdata_o[15:8] = ~rdata_o[15:8];
		if (lower_lane_n_i && flag_select_n_i) rdata_o[7:0] = ~rdata_o[7:0];
		if (!busy_n_o) rdata_o = ~rdata_o;
	end
endmodule : dpc_dev_model

// >>> tb/dpc_host_props.sv
/*
 Pin sequencing checker for dpc_host.
 Assumes the bind below and a synchronous active-high reset.
*/
`timescale 1ns/1ps
module dpc_host_props
	import dpc_pkg::*;
(
	input wire logic              sys_clk_i,
	input wire logic              rst_i,
	input wire logic              alert_o,
	input wire logic              port_sel_n_o,
	input wire logic              flag_select_n_o,
	input wire logic              wr_n_o,
	input wire logic              rd_oe_n_o,
	input wire logic [ADDR_W-1:0] addr_o,
	input wire logic              slave_mode_i,
	input wire logic              busy_n_i,
	input wire logic              alert_n_i
);
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);
	// Strobe and select relations
	chk_read_strobe_high: assert property (!rd_oe_n_o |-> wr_n_o)
		else $error("write strobe low during read");
	chk_addr_strobe_high: assert property (!$stable(addr_o) |-> wr_n_o)
		else $error("address moved with write strobe low");
	chk_flag_port_idle: assert property (!flag_select_n_o |-> port_sel_n_o)
		else $error("port select low during flag access");
	chk_mem_flag_off: assert property (!port_sel_n_o |-> flag_select_n_o)
		else $error("flag select low during memory access");
	// Flag write pulse length and read-back spacing
	chk_flag_pulse: assert property ($fell(flag_select_n_o) && !wr_n_o |->
		(!flag_select_n_o && !wr_n_o)[*4]) else $error("flag write pulse too short");
	chk_flag_gap: assert property ($rose(flag_select_n_o) && $past(wr_n_o) == 1'b0 |->
		(flag_select_n_o || !wr_n_o)[*3]) else $error("flag read too soon after write");
	// Holds after the collision indicator returns high
	chk_slave_wr_hold: assert property (slave_mode_i && !wr_n_o && $rose(busy_n_i) |->
		##1 (!wr_n_o)[*8]) else $error("slave write strobe released early");
	chk_busy_read_hold: assert property (!rd_oe_n_o && $rose(busy_n_i) |->
		##1 (!rd_oe_n_o)[*8]) else $error("held-off read ended early");
	// Mailbox alert follows the pin
	chk_alert_set: assert property ($fell(alert_n_i) |-> ##[1:5] alert_o)
		else $error("alert not raised");
	chk_alert_clear: assert property ($rose(alert_n_i) |-> ##[1:5] !alert_o)
		else $error("alert not cleared");
endmodule : dpc_host_props
bind dpc_host dpc_host_props u_dpc_host_props (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
	.alert_o(alert_o), .port_sel_n_o(port_sel_n_o), .flag_select_n_o(flag_select_n_o),
	.wr_n_o(wr_n_o), .rd_oe_n_o(rd_oe_n_o), .addr_o(addr_o), .slave_mode_i(slave_mode_i),
	.busy_n_i(busy_n_i), .alert_n_i(alert_n_i));

// >>> tb/tb.sv
/*
 Self-checking bench: dpc_host against the memory model.
 Assumes the checker is bound in; inputs change on the falling edge.
*/
`timescale 1ns/1ps
module tb;
	import dpc_pkg::*;
	logic sys_clk_i = 1'b0, rst_i = 1'b1, req_valid_i = 1'b0, slave_mode_i = 1'b0;
	logic hold_busy = 1'b0, peer_mail = 1'b0, dev_drv, busy_n, alert_n;
	logic req_ready_o, rsp_valid_o, rsp_granted_o, alert_o, data_oe_o;
	logic sel_n, flag_n, wr_n, oe_n, upper_lane_n, lower_lane_n;
	dpc_cmd_t req_cmd_i = DPC_CMD_READ;
	logic [13:0] req_addr_i = 14'h0000, addr_o, a;
	logic [15:0] req_wdata_i = 16'h0000, rsp_rdata_o, data_o, dev_rd, d, bus_q = 16'h0000;
	logic [15:0] ref_m [0:7] = '{default: 16'h0000};
	logic [1:0] req_lanes_i = 2'h3, l;
	logic [7:0] peer_own = 8'h00;
	int fail_count = 0, num_checks = 0, i, seed;
	// Bus: controller, then device, else a changing junk pattern
	wire [15:0] bus = data_oe_o ? data_o : (dev_drv ? dev_rd : ~bus_q);
	always @(posedge sys_clk_i) bus_q <= bus;
	always #2 sys_clk_i = ~sys_clk_i;
	dpc_host u_dpc_host (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .req_valid_i(req_valid_i),
		.req_ready_o(req_ready_o), .req_cmd_i(req_cmd_i), .req_addr_i(req_addr_i),
		.req_wdata_i(req_wdata_i), .req_lanes_i(req_lanes_i), .slave_mode_i(slave_mode_i),
		.rsp_valid_o(rsp_valid_o), .rsp_rdata_o(rsp_rdata_o), .rsp_granted_o(rsp_granted_o),
		.alert_o(alert_o), .port_sel_n_o(sel_n), .flag_select_n_o(flag_n), .wr_n_o(wr_n),
		.rd_oe_n_o(oe_n), .upper_lane_n_o(upper_lane_n), .lower_lane_n_o(lower_lane_n),
		.addr_o(addr_o),
		.data_i(bus), .data_o(data_o), .data_oe_o(data_oe_o), .busy_n_i(busy_n),
		.alert_n_i(alert_n));
	dpc_dev_model u_dpc_dev_model (.port_sel_n_i(sel_n), .flag_select_n_i(flag_n),
		.wr_n_i(wr_n), .rd_oe_n_i(oe_n), .upper_lane_n_i(upper_lane_n),
		.lower_lane_n_i(lower_lane_n),
		.addr_i(addr_o), .wdata_i(bus), .slave_mode_i(slave_mode_i), .hold_busy_i(hold_busy),
		.peer_own_i(peer_own), .peer_mail_i(peer_mail), .rdata_o(dev_rd), .drive_o(dev_drv),
		.busy_n_o(busy_n), .alert_n_o(alert_n));
	// Byte mask of the enabled lanes
	function automatic logic [15:0] lmask(input logic [1:0] ln);
		return {{8{ln[1]}}, {8{ln[0]}}};
	endfunction : lmask
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic stop_test(input bit timed_out);
		if (timed_out) fail_count++;
		if (fail_count == 0 && num_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : stop_test
	// One request: wait idle, present one cycle, wait for the answer
	task automatic run(input dpc_cmd_t c, input logic [13:0] ad, input logic [15:0] wd,
		input logic [1:0] ln);
		int n;
		n = 0;
		while (req_ready_o !== 1'b1) begin
			@(negedge sys_clk_i);
			n++;
			if (n > 400) stop_test(1'b1);
		end
		@(negedge sys_clk_i);
		req_valid_i = 1'b1;
		req_cmd_i = c;
		req_addr_i = ad;
		req_wdata_i = wd;
		req_lanes_i = ln;
		@(negedge sys_clk_i);
		req_valid_i = 1'b0;
		n = 0;
		while (rsp_valid_o !== 1'b1) begin
			@(negedge sys_clk_i);
			n++;
			if (n > 400) stop_test(1'b1);
		end
	endtask : run
	initial begin
		seed = 32'he724;
		repeat (16) @(negedge sys_clk_i);
		rst_i = 1'b0;
		// Random byte-lane traffic on a small window
		for (i = 0; i < 60; i++) begin
			a = 14'($unsigned($random(seed)) % 8);
			l = 2'($unsigned($random(seed)) % 3 + 1);
			d = 16'($random(seed));
			if ($random(seed) & 1) begin
				run(DPC_CMD_WRITE, a, d, l);
				ref_m[a[2:0]] = (ref_m[a[2:0]] & ~lmask(l)) | (d & lmask(l));
			end else begin
				run(DPC_CMD_READ, a, 16'h0000, l);
				check(rsp_rdata_o & lmask(l), ref_m[a[2:0]] & lmask(l));
			end
		end
		// Claims against a randomly held far side, each freed after
		for (i = 0; i < 8; i++) begin
			peer_own = 8'($random(seed));
			run(DPC_CMD_CLAIM, 14'(i), 16'h0000, 2'h3);
			check({15'h0000, rsp_granted_o}, {15'h0000, !peer_own[i]});
			run(DPC_CMD_FREE, 14'(i), 16'h0000, 2'h3);
		end
		// Read held off by the collision indicator
		hold_busy = 1'b1;
		fork
			run(DPC_CMD_READ, 14'h0005, 16'h0000, 2'h3);
			begin
				repeat (25) @(negedge sys_clk_i);
				hold_busy = 1'b0;
			end
		join
		check(rsp_rdata_o, ref_m[5]);
		// Slave write held by the indicator, then read back
		slave_mode_i = 1'b1;
		hold_busy = 1'b1;
		fork
			run(DPC_CMD_WRITE, 14'h0006, 16'h5aa5, 2'h3);
			begin
				repeat (25) @(negedge sys_clk_i);
				hold_busy = 1'b0;
			end
		join
		slave_mode_i = 1'b0;
		run(DPC_CMD_READ, 14'h0006, 16'h0000, 2'h3);
		check(rsp_rdata_o, 16'h5aa5);
		// Mailbox alert set by the far side, cleared by our read
		peer_mail = 1'b1;
		repeat (8) @(negedge sys_clk_i);
		check({15'h0000, alert_o}, 16'h0001);
		peer_mail = 1'b0;
		run(DPC_CMD_READ, 14'h3fff, 16'h0000, 2'h3);
		repeat (8) @(negedge sys_clk_i);
		check({15'h0000, alert_o}, 16'h0000);
		stop_test(1'b0);
	end
endmodule : tb
